/* File: core/sbl_loader.v */
// Purpose: Serial boot command handler for flash writing and RAM loading.
// Assumes: Memory answers a read on MEM_RDATA_I one cycle after MEM_RD_O.
// Notes:   Every halt is left only through RST_N_I.
// Function
// - Auto-baud on sync byte, echo, else silent
// - Third byte: echo baud or error thrice, halt
// - Echo command byte; same rate afterwards
// - Bad command: error code thrice, halt
// - Two 24-bit password addresses, no reply
// - Compare N bytes from compare address
// - Password mismatch halts silently
// - Erased top 32 bytes skip password
// - Bad password addresses halt until reset
// - Read protection halts instead of command
// - Receive error in password phase halts
// - No echo during hex download
// - Ignore bytes until start mark
// - Record: length, address, type, data, checksum
// - RAM mode writes record data at address
// - Receive or format error halts silently
// - After end record send sum, upper first
// - Flash mode returns to command wait
// - RAM mode jumps to first data record address
`include "sbl_consts.vh"

module sbl_loader #(
  parameter DIV_W = 16,
  parameter INIT_BIT_CYC = `SBL_INIT_BIT_CYC
) (
  input wire REF_CLK_I,
  input wire RST_N_I,
  input wire RXD_I,
  output wire TXD_O,
  input wire RD_PROTECT_I,
  output reg MEM_RD_O,
  output reg MEM_WR_O,
  output reg MEM_RAM_SEL_O,
  output reg [23:0] MEM_ADDR_O,
  output reg [7:0] MEM_WDATA_O,
  input wire [7:0] MEM_RDATA_I,
  output reg HALTED_O,
  output reg JUMP_O,
  output reg [23:0] JUMP_ADDR_O
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam S_MEAS = 5'd0;
  localparam S_SKIP = 5'd1;
  localparam S_SYNC = 5'd2;
  localparam S_TX = 5'd3;
  localparam S_BAUD = 5'd4;
  localparam S_CMD = 5'd5;
  localparam S_ADDR = 5'd6;
  localparam S_BLANK = 5'd7;
  localparam S_CNT = 5'd8;
  localparam S_PW = 5'd9;
  localparam S_HIDLE = 5'd10;
  localparam S_HLEN = 5'd11;
  localparam S_HAH = 5'd12;
  localparam S_HAL = 5'd13;
  localparam S_HTYPE = 5'd14;
  localparam S_HDATA = 5'd15;
  localparam S_HCK = 5'd16;
  localparam S_SUMLO = 5'd17;
  localparam S_JUMP = 5'd18;
  localparam S_RUN = 5'd19;
  localparam S_HALT = 5'd20;

  localparam [DIV_W-1:0] INIT_DIV = INIT_BIT_CYC[DIV_W-1:0];
  localparam [DIV_W-1:0] DIV_TOL = INIT_DIV >> 3;

  function [23:0] add24;
    input [23:0] a;
    input [23:0] b;
    begin
      add24 = a + b;
    end
  endfunction

  reg [4:0] st_q;
  reg [4:0] ret_q;
  reg [DIV_W-1:0] div_q;
  reg [19:0] cnt_q;
  reg [7:0] idx_q;
  reg [1:0] ph_q;
  reg [47:0] pw_addr_q;
  reg [7:0] pw_n_q;
  reg [7:0] hold_q;
  reg blank_q;
  reg tx_go_q;
  reg [7:0] tx_byte_q;
  reg [1:0] rep_q;
  reg [7:0] len_q;
  reg [15:0] rec_addr_q;
  reg [7:0] type_q;
  reg [7:0] ck_q;
  reg [15:0] ext_q;
  reg [23:0] base_q;
  reg first_q;
  reg [15:0] sum_q;

  wire rx_valid;
  wire [7:0] rx_byte;
  wire rx_ferr;
  wire tx_done;
  wire [DIV_W-1:0] half = cnt_q[DIV_W:1];
  wire [DIV_W-1:0] dev = (half > INIT_DIV) ? half - INIT_DIV : INIT_DIV - half;
  // The receiver is held idle while the bit time is being measured and the rest of its frame skipped, after the jump and once halted.
  wire rx_en = (st_q != S_MEAS) && (st_q != S_SKIP) && (st_q != S_HALT) &&
               (st_q != S_RUN);
  wire [7:0] ck_next = ck_q + rx_byte;

  sbl_uart #(.DIV_W(DIV_W)) u_uart (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .div_i(div_q),
    .rx_en_i(rx_en),
    .rxd_i(RXD_I),
    .tx_go_i(tx_go_q),
    .tx_byte_i(tx_byte_q),
    .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte),
    .rx_ferr_o(rx_ferr),
    .tx_done_o(tx_done),
    .txd_o(TXD_O)
  );

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= S_MEAS;
      ret_q <= S_MEAS;
      div_q <= INIT_DIV;
      cnt_q <= 20'h0_0000;
      idx_q <= 8'h00;
      ph_q <= 2'h0;
      pw_addr_q <= 48'h0000_0000_0000;
      pw_n_q <= 8'h00;
      hold_q <= 8'h00;
      blank_q <= 1'b0;
      tx_go_q <= 1'b0;
      tx_byte_q <= 8'h00;
      rep_q <= 2'h0;
      len_q <= 8'h00;
      rec_addr_q <= 16'h0000;
      type_q <= 8'h00;
      ck_q <= 8'h00;
      ext_q <= 16'h0000;
      base_q <= 24'h00_0000;
      first_q <= 1'b0;
      sum_q <= 16'h0000;
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
      MEM_RAM_SEL_O <= 1'b0;
      MEM_ADDR_O <= 24'h00_0000;
      MEM_WDATA_O <= 8'h00;
      HALTED_O <= 1'b0;
      JUMP_O <= 1'b0;
      JUMP_ADDR_O <= 24'h00_0000;
    end else begin
      tx_go_q <= 1'b0;
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
      JUMP_O <= 1'b0;
      case (st_q)
        // The sync byte opens with start plus a low bit 0, so its first low
        // pulse is two bit times long; half of it becomes the bit time.
        S_MEAS: begin
          if (!RXD_I) begin
            if (cnt_q[16:0] != 17'h1_FFFF) begin
              cnt_q <= cnt_q + 20'h0_0001;
            end
          end else if (cnt_q != 20'h0_0000) begin
            if (dev <= DIV_TOL) begin
              div_q <= half;
              cnt_q <= {1'b0, half, 3'b000};
              st_q <= S_SKIP;
            end else begin
              cnt_q <= 20'h0_0000;
            end
          end
        end
        // Let the rest of the measured frame pass before listening.
        S_SKIP: begin
          if (cnt_q == 20'h0_0000) begin
            st_q <= S_SYNC;
          end else begin
            cnt_q <= cnt_q - 20'h0_0001;
          end
        end
        S_SYNC: begin
          if (rx_valid) begin
            if (!rx_ferr && rx_byte == `SBL_SYNC_BYTE) begin
              tx_byte_q <= rx_byte;
              rep_q <= 2'h1;
              tx_go_q <= 1'b1;
              ret_q <= S_BAUD;
              st_q <= S_TX;
            end else begin
              cnt_q <= 20'h0_0000;
              st_q <= S_MEAS;
            end
          end
        end
        S_TX: begin
          if (tx_done) begin
            if (rep_q == 2'h1) begin
              st_q <= ret_q;
            end else begin
              rep_q <= rep_q - 2'h1;
              tx_go_q <= 1'b1;
            end
          end
        end
        S_BAUD: begin
          if (rx_valid) begin
            tx_go_q <= 1'b1;
            st_q <= S_TX;
            if (rx_ferr) begin
              tx_byte_q <= `SBL_ERR_RXE;
              rep_q <= `SBL_ERR_REPEAT;
              ret_q <= S_HALT;
            end else if (rx_byte == `SBL_BAUD_INIT) begin
              tx_byte_q <= rx_byte;
              rep_q <= 2'h1;
              ret_q <= S_CMD;
            end else begin
              tx_byte_q <= `SBL_ERR_BAUD;
              rep_q <= `SBL_ERR_REPEAT;
              ret_q <= S_HALT;
            end
          end
        end
        S_CMD: begin
          if (rx_valid) begin
            first_q <= 1'b0;
            sum_q <= 16'h0000;
            base_q <= 24'h00_0000;
            idx_q <= 8'h00;
            rep_q <= `SBL_ERR_REPEAT;
            ret_q <= S_HALT;
            tx_go_q <= 1'b1;
            st_q <= S_TX;
            if (rx_ferr) begin
              tx_byte_q <= `SBL_ERR_RXE;
            end else if (rx_byte != `SBL_CMD_FLASH && rx_byte != `SBL_CMD_RAM) begin
              tx_byte_q <= `SBL_ERR_CMD;
            end else if (RD_PROTECT_I) begin
              tx_go_q <= 1'b0;
              st_q <= S_HALT;
            end else begin
              MEM_RAM_SEL_O <= (rx_byte == `SBL_CMD_RAM);
              tx_byte_q <= rx_byte;
              rep_q <= 2'h1;
              ret_q <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (rx_valid) begin
            if (rx_ferr) begin
              st_q <= S_HALT;
            end else begin
              pw_addr_q <= {pw_addr_q[39:0], rx_byte};
              idx_q <= idx_q + 8'h01;
              if (idx_q == `SBL_ADDR_BYTES) begin
                idx_q <= 8'h00;
                ph_q <= 2'h0;
                blank_q <= 1'b1;
                st_q <= S_BLANK;
              end
            end
          end
        end
        // Reads take three phases: issue, wait, sample.
        S_BLANK: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            MEM_RD_O <= 1'b1;
            MEM_ADDR_O <= add24(`SBL_BLANK_BASE, {16'h0000, idx_q});
          end else if (ph_q == 2'h2) begin
            ph_q <= 2'h0;
            idx_q <= idx_q + 8'h01;
            if (idx_q == `SBL_BLANK_LAST) begin
              idx_q <= 8'h00;
              if (blank_q && MEM_RDATA_I == `SBL_ERASED) begin
                st_q <= S_HIDLE;
              end else begin
                st_q <= S_CNT;
              end
            end else if (MEM_RDATA_I != `SBL_ERASED) begin
              blank_q <= 1'b0;
            end
          end
        end
        S_CNT: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            MEM_RD_O <= 1'b1;
            MEM_ADDR_O <= pw_addr_q[47:24];
          end else if (ph_q == 2'h2) begin
            ph_q <= 2'h0;
            pw_n_q <= MEM_RDATA_I;
            // A zero count means the count address was wrong.
            st_q <= (MEM_RDATA_I == 8'h00) ? S_HALT : S_PW;
          end
        end
        S_PW: begin
          if (ph_q == 2'h0) begin
            if (rx_valid) begin
              if (rx_ferr) begin
                st_q <= S_HALT;
              end else begin
                hold_q <= rx_byte;
                MEM_RD_O <= 1'b1;
                MEM_ADDR_O <= add24(pw_addr_q[23:0], {16'h0000, idx_q});
                ph_q <= 2'h1;
              end
            end
          end else if (ph_q == 2'h1) begin
            ph_q <= 2'h2;
          end else begin
            ph_q <= 2'h0;
            idx_q <= idx_q + 8'h01;
            if (MEM_RDATA_I != hold_q) begin
              st_q <= S_HALT;
            end else if (idx_q + 8'h01 == pw_n_q) begin
              st_q <= S_HIDLE;
            end
          end
        end
        // No branch below starts the transmitter until the sum is due.
        S_HIDLE: begin
          if (rx_valid) begin
            if (rx_ferr) begin
              st_q <= S_HALT;
            end else if (rx_byte == `SBL_START_MARK) begin
              st_q <= S_HLEN;
            end
          end
        end
        S_HLEN, S_HAH, S_HAL, S_HTYPE, S_HDATA, S_HCK: begin
          if (rx_valid) begin
            ck_q <= ck_next;
            if (rx_ferr) begin
              st_q <= S_HALT;
            end else if (st_q == S_HLEN) begin
              len_q <= rx_byte;
              ck_q <= rx_byte;
              st_q <= S_HAH;
            end else if (st_q == S_HAH) begin
              rec_addr_q[15:8] <= rx_byte;
              st_q <= S_HAL;
            end else if (st_q == S_HAL) begin
              rec_addr_q[7:0] <= rx_byte;
              st_q <= S_HTYPE;
            end else if (st_q == S_HTYPE) begin
              type_q <= rx_byte;
              idx_q <= 8'h00;
              st_q <= (len_q == 8'h00) ? S_HCK : S_HDATA;
              if (!((rx_byte == `SBL_REC_DATA) ||
                    (rx_byte == `SBL_REC_END && len_q == 8'h00) ||
                    ((rx_byte == `SBL_REC_SEG || rx_byte == `SBL_REC_LIN) &&
                     len_q == 8'h02))) begin
                st_q <= S_HALT;
              end
            end else if (st_q == S_HDATA) begin
              idx_q <= idx_q + 8'h01;
              if (idx_q + 8'h01 == len_q) begin
                st_q <= S_HCK;
              end
              if (type_q == `SBL_REC_DATA) begin
                MEM_WR_O <= 1'b1;
                MEM_ADDR_O <= add24(base_q, {8'h00, rec_addr_q + {8'h00, idx_q}});
                MEM_WDATA_O <= rx_byte;
                sum_q <= sum_q + {8'h00, rx_byte};
                if (!first_q) begin
                  first_q <= 1'b1;
                  JUMP_ADDR_O <= add24(base_q, {8'h00, rec_addr_q});
                end
              end else begin
                ext_q <= {ext_q[7:0], rx_byte};
              end
            end else begin
              st_q <= S_HIDLE;
              if (ck_next != 8'h00) begin
                st_q <= S_HALT;
              end else if (type_q == `SBL_REC_END) begin
                tx_byte_q <= sum_q[15:8];
                rep_q <= 2'h1;
                tx_go_q <= 1'b1;
                ret_q <= S_SUMLO;
                st_q <= S_TX;
              end else if (type_q == `SBL_REC_SEG) begin
                base_q <= {4'h0, ext_q, 4'h0};
              end else if (type_q == `SBL_REC_LIN) begin
                base_q <= {ext_q[7:0], 16'h0000};
              end
            end
          end
        end
        S_SUMLO: begin
          tx_byte_q <= sum_q[7:0];
          rep_q <= 2'h1;
          tx_go_q <= 1'b1;
          ret_q <= MEM_RAM_SEL_O ? S_JUMP : S_CMD;
          st_q <= S_TX;
        end
        S_JUMP: begin
          JUMP_O <= 1'b1;
          st_q <= S_RUN;
        end
        S_RUN: begin
          st_q <= S_RUN;
        end
        S_HALT: begin
          HALTED_O <= 1'b1;
        end
        default: begin
          st_q <= S_HALT;
        end
      endcase
    end
  end

endmodule

/* File: shared/sbl_consts.vh */
// Purpose: Constants for the serial boot loader command handler.
// Assumes: A 250 MHz reference clock.
// Notes:   Byte codes, memory windows and timing figures, all as macros.
`ifndef SBL_CONSTS_VH
`define SBL_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define SBL_CLK_HZ 250000000
`define SBL_INIT_BAUD 9600
// Bit time at the initial rate, in clock cycles.
`define SBL_INIT_BIT_CYC (`SBL_CLK_HZ / `SBL_INIT_BAUD)
// Repeats of an error code before the halt.
`define SBL_ERR_REPEAT 2'h3

// ****************************************************************
// Serial byte codes
// ****************************************************************
`define SBL_SYNC_BYTE 8'h5A
`define SBL_BAUD_INIT 8'h28
`define SBL_CMD_FLASH 8'h30
`define SBL_CMD_RAM 8'h60
`define SBL_ERR_RXE 8'hA1
`define SBL_ERR_AUX 8'hA3
`define SBL_ERR_BAUD 8'h62
`define SBL_ERR_CMD 8'h63
`define SBL_START_MARK 8'h3A
`define SBL_ERASED 8'hFF

// ****************************************************************
// Hex record types
// ****************************************************************
`define SBL_REC_DATA 8'h00
`define SBL_REC_END 8'h01
`define SBL_REC_SEG 8'h02
`define SBL_REC_LIN 8'h04

// ****************************************************************
// Memory windows
// ****************************************************************
`define SBL_BLANK_BASE 24'h0F_FFE0
`define SBL_BLANK_LAST 8'h1F
`define SBL_ADDR_BYTES 8'h05

`endif

/* File: core/sbl_uart.v */
// Purpose: Byte-level serial receiver and transmitter, 8N1, run-time bit time.
// Assumes: Receive line synchronous to the clock; divider given in cycles per bit.
// Notes:   Receive samples at mid-bit; framing error is a low stop bit.
`include "sbl_consts.vh"

module sbl_uart #(
  parameter DIV_W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [DIV_W-1:0] div_i,
  input wire rx_en_i,
  input wire rxd_i,
  input wire tx_go_i,
  input wire [7:0] tx_byte_i,
  output reg rx_valid_o,
  output reg [7:0] rx_byte_o,
  output reg rx_ferr_o,
  output reg tx_done_o,
  output reg txd_o
);

  // ****************************************************************
  // Receiver
  // ****************************************************************
  reg rx_run_q;
  reg [DIV_W-1:0] rx_cnt_q;
  reg [3:0] rx_bit_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_run_q <= 1'b0;
      rx_cnt_q <= {DIV_W{1'b0}};
      rx_bit_q <= 4'h0;
      rx_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_ferr_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rx_en_i) begin
        rx_run_q <= 1'b0;
      end else if (!rx_run_q) begin
        if (!rxd_i) begin
          rx_run_q <= 1'b1;
          rx_cnt_q <= div_i >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != {DIV_W{1'b0}}) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= div_i - 1'b1;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          // A start bit that is high again at mid-bit was a glitch.
          if (rxd_i) begin
            rx_run_q <= 1'b0;
          end
        end else if (rx_bit_q == 4'h9) begin
          rx_run_q <= 1'b0;
          rx_valid_o <= 1'b1;
          rx_ferr_o <= !rxd_i;
        end else begin
          rx_byte_o <= {rxd_i, rx_byte_o[7:1]};
        end
      end
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  reg tx_busy_q;
  reg [DIV_W-1:0] tx_cnt_q;
  reg [3:0] tx_left_q;
  reg [8:0] tx_sh_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= {DIV_W{1'b0}};
      tx_left_q <= 4'h0;
      tx_sh_q <= 9'h1FF;
      tx_done_o <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      tx_done_o <= 1'b0;
      if (!tx_busy_q) begin
        if (tx_go_i) begin
          tx_busy_q <= 1'b1;
          txd_o <= 1'b0;
          tx_sh_q <= {1'b1, tx_byte_i};
          tx_left_q <= 4'h9;
          tx_cnt_q <= div_i - 1'b1;
        end
      end else if (tx_cnt_q != {DIV_W{1'b0}}) begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end else if (tx_left_q == 4'h0) begin
        tx_busy_q <= 1'b0;
        tx_done_o <= 1'b1;
      end else begin
        txd_o <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[8:1]};
        tx_left_q <= tx_left_q - 4'h1;
        tx_cnt_q <= div_i - 1'b1;
      end
    end
  end

endmodule

/* File: sim/sbl_loader_chk.sv */
// Purpose: Port-level checks of the boot loader command handler.
// Assumes: Serial bit times of at least eight clock cycles.
// Notes:   Bound onto every loader instance.
module sbl_loader_chk (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic RXD_I,
  input wire logic TXD_O,
  input wire logic MEM_RD_O,
  input wire logic MEM_WR_O,
  input wire logic MEM_RAM_SEL_O,
  input wire logic HALTED_O,
  input wire logic JUMP_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_halt_sticky: assert property (HALTED_O |=> HALTED_O)
    else $error("halt left without reset");
  a_halt_quiet: assert property (HALTED_O |-> TXD_O && !MEM_WR_O && !MEM_RD_O && !JUMP_O)
    else $error("activity while halted");
  a_halt_entry: assert property ($rose(HALTED_O) |-> $past(TXD_O, 8) && TXD_O)
    else $error("halt entered in mid-frame");
  a_rd_wr_apart: assert property (!(MEM_RD_O && MEM_WR_O))
    else $error("read and write together");
  a_wr_pulse_once: assert property (MEM_WR_O |=> !MEM_WR_O [*8])
    else $error("write strobe repeated");
  a_wr_no_echo: assert property (MEM_WR_O |-> TXD_O && RXD_I)
    else $error("write outside a quiet stop bit");
  a_start_bit: assert property ($fell(TXD_O) |-> !TXD_O [*8])
    else $error("short serial bit");
  a_jump_ram: assert property (JUMP_O |-> MEM_RAM_SEL_O)
    else $error("jump outside RAM loading");
  a_jump_after_sum: assert property (JUMP_O |-> $past(TXD_O, 8) && TXD_O)
    else $error("jump before checksum sent");
  a_jump_final: assert property (JUMP_O |=> (!JUMP_O && !MEM_WR_O && TXD_O) [*8])
    else $error("activity after jump");
endmodule

bind sbl_loader sbl_loader_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
  .RXD_I(RXD_I), .TXD_O(TXD_O), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
  .MEM_RAM_SEL_O(MEM_RAM_SEL_O), .HALTED_O(HALTED_O), .JUMP_O(JUMP_O));

/* File: sim/sbl_host_model.sv */
// Purpose: Host controller model for the boot link, 8N1 in both directions.
// Assumes: One fixed bit time in clock cycles for both directions.
// Notes:   The line moves only at falling clock edges and idles high.
module sbl_host_model #(
  parameter int BIT = 64
) (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b;

  initial begin
    rxd_o = 1'b1;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end

  // A low stop bit makes a framing fault on purpose.
  task automatic send_byte(input logic [7:0] d, input logic bad);
    logic [9:0] fr;
    fr = {~bad, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      rxd_o = fr[i];
      repeat (BIT - 1) @(negedge clk_i);
    end
    if (bad) begin
      @(negedge clk_i);
      rxd_o = 1'b1;
    end
  endtask

  // Bytes are handed on after the last data bit, so replies are seen early.
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      b[i] = txd_i;
    end
    rx_byte_o <= b;
    rx_valid_o <= 1'b1;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
  end
endmodule

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench of the boot loader command handler.
// Assumes: Initial bit time shortened to 32 cycles.
// Notes:   Replies, memory writes and jumps are expected in queue order.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_prot = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic txd, rxd, mem_rd, mem_wr, ram_sel, halted, jump, host_v, ram, first_ok;
  logic [23:0] mem_addr, jump_addr, base, first;
  logic [7:0] mem_wdata, host_b;
  logic [15:0] sum;
  logic [7:0] mem [logic [23:0]];
  logic [35:0] exp_q[$];
  int fail_count = 0;
  int compares = 0;

  always #2 ref_clk = ~ref_clk;

  sbl_loader #(.DIV_W(16), .INIT_BIT_CYC(BIT)) DUT (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
    .RXD_I(rxd), .TXD_O(txd), .RD_PROTECT_I(rd_prot), .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr),
    .MEM_RAM_SEL_O(ram_sel), .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata),
    .MEM_RDATA_I(mem_rdata), .HALTED_O(halted), .JUMP_O(jump), .JUMP_ADDR_O(jump_addr));
  sbl_host_model #(.BIT(BIT)) u_host (.clk_i(ref_clk), .txd_i(txd), .rxd_o(rxd),
    .rx_valid_o(host_v), .rx_byte_o(host_b));

  // Unwritten locations read as erased.
  always @(negedge ref_clk) begin
    if (mem_rd === 1'b1) mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 8'hFF;
  end

  task automatic test_done;
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // An event with nothing queued meets an impossible value and fails.
  task automatic take(input logic [35:0] seen);
    check(seen, exp_q.size() != 0 ? exp_q.pop_front() : 36'hF_FFFF_FFFF);
  endtask

  always @(negedge ref_clk) begin
    if (host_v === 1'b1) take({12'h001, 16'h0000, host_b});
    if (mem_wr === 1'b1) take({3'b001, ram_sel, mem_addr, mem_wdata});
    if (jump === 1'b1) take({4'h4, jump_addr, 8'h00});
  end

  task automatic tx(input logic [7:0] b);
    exp_q.push_back({12'h001, 16'h0000, b});
  endtask

  task automatic wait_q;
    for (int i = 0; i < 30000 && exp_q.size() != 0; i++) @(negedge ref_clk);
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("[FAIL] %0t expected event missing", $time);
      test_done();
    end
    repeat (2 * BIT) @(negedge ref_clk);
  endtask

  task automatic send(input logic [7:0] b);
    u_host.send_byte(b, 1'b0);
  endtask

  task automatic xfer(input logic [7:0] b, input logic bad, input logic [7:0] r, input int n);
    for (int i = 0; i < n; i++) tx(r);
    u_host.send_byte(b, bad);
    wait_q();
  endtask

  // Every event queued before the halt must have been seen first.
  task automatic halt_wait;
    wait_q();
    for (int i = 0; i < 20000 && halted !== 1'b1; i++) @(negedge ref_clk);
    check({35'h0, halted}, 36'h1);
    if (halted !== 1'b1) test_done();
  endtask

  task automatic reset_dut(input logic r);
    @(negedge ref_clk);
    rst_n = 1'b0;
    rd_prot = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    base = 24'h00_0000;
    sum = 16'h0000;
    first_ok = 1'b0;
    ram = r;
  endtask

  // The host repeats the sync byte; the second copy is the one received.
  task automatic sync;
    tx(8'h5A);
    send(8'h5A);
    xfer(8'h5A, 1'b0, 8'h00, 0);
  endtask

  task automatic start(input logic [7:0] cmd, input logic [7:0] r, input int n);
    sync();
    xfer(8'h28, 1'b0, 8'h28, 1);
    xfer(cmd, 1'b0, r, n);
  endtask

  task automatic addrs(input logic [23:0] c, input logic [23:0] p);
    logic [47:0] a;
    a = {c, p};
    for (int i = 5; i >= 0; i--) xfer(a[i*8 +: 8], 1'b0, 8'h00, 0);
  endtask

  task automatic rec(input logic [7:0] t, input logic [15:0] a, input int n,
                     input logic [15:0] v, input logic bad);
    logic [7:0] d;
    logic [7:0] ck;
    ck = n[7:0] + a[15:8] + a[7:0] + t;
    send(8'h3A);
    send(n[7:0]);
    send(a[15:8]);
    send(a[7:0]);
    send(t);
    for (int i = 0; i < n; i++) begin
      d = (t != 8'h00) ? v[15 - 8 * i -: 8] : 8'($urandom);
      ck += d;
      if (t == 8'h00) begin
        if (!first_ok) first = base + a;
        first_ok = 1'b1;
        sum += d;
        exp_q.push_back({3'b001, ram, base + a + i[23:0], d});
      end
      send(d);
    end
    send(8'h00 - ck + {7'h00, bad});
    if (t == 8'h04) base = {v[7:0], 16'h0000};
    if (t == 8'h02) base = {4'h0, v, 4'h0};
    if (t == 8'h01) begin
      tx(sum[15:8]);
      tx(sum[7:0]);
      if (ram) exp_q.push_back({4'h4, first, 8'h00});
    end
  endtask

  initial begin
    void'($urandom(16040));
    reset_dut(1'b1);
    start(8'h60, 8'h60, 1);
    addrs(24'h00_1000, 24'h00_2000);
    send(8'h55);
    rec(8'h04, 16'h0000, 2, 16'h0001, 1'b0);
    rec(8'h00, 16'h0200, 2, 16'h0000, 1'b0);
    rec(8'h02, 16'h0000, 2, 16'h0100, 1'b0);
    rec(8'h00, 16'h0010, 1, 16'h0000, 1'b0);
    rec(8'h01, 16'h0000, 0, 16'h0000, 1'b0);
    wait_q();
    reset_dut(1'b1);
    start(8'h60, 8'h60, 1);
    addrs(24'h00_1000, 24'h00_2000);
    rec(8'h00, 16'h0400, 2, 16'h0000, 1'b1);
    halt_wait();
    reset_dut(1'b0);
    mem[24'h0F_FFE0] = 8'h00;
    mem[24'h00_1000] = 8'h02;
    mem[24'h00_2000] = 8'hA5;
    mem[24'h00_2001] = 8'h3C;
    start(8'h30, 8'h30, 1);
    addrs(24'h00_1000, 24'h00_2000);
    xfer(8'hA5, 1'b0, 8'h00, 0);
    xfer(8'h3C, 1'b0, 8'h00, 0);
    rec(8'h00, 16'h0300, 1, 16'h0000, 1'b0);
    rec(8'h01, 16'h0000, 0, 16'h0000, 1'b0);
    wait_q();
    xfer(8'h60, 1'b0, 8'h60, 1);
    reset_dut(1'b0);
    start(8'h30, 8'h30, 1);
    addrs(24'h00_1000, 24'h00_2000);
    xfer(8'hA5, 1'b0, 8'h00, 0);
    xfer(8'h00, 1'b0, 8'h00, 0);
    halt_wait();
    reset_dut(1'b0);
    start(8'h30, 8'h30, 1);
    addrs(24'h0F_FFE0, 24'h00_2000);
    halt_wait();
    reset_dut(1'b0);
    // A frame after the measured one that is not the sync byte must draw no reply.
    send(8'h5A);
    send(8'h55);
    sync();
    xfer(8'h33, 1'b0, 8'h62, 3);
    halt_wait();
    xfer(8'h5A, 1'b0, 8'h00, 0);
    xfer(8'h5A, 1'b0, 8'h00, 0);
    reset_dut(1'b0);
    sync();
    xfer(8'h28, 1'b1, 8'hA1, 3);
    halt_wait();
    reset_dut(1'b0);
    start(8'h77, 8'h63, 3);
    halt_wait();
    reset_dut(1'b0);
    rd_prot = 1'b1;
    start(8'h60, 8'h00, 0);
    halt_wait();
    reset_dut(1'b0);
    start(8'h60, 8'h60, 1);
    xfer(8'h00, 1'b1, 8'h00, 0);
    halt_wait();
    test_done();
  end
endmodule
